// *** pkg/prm_pkg.sv ***
`default_nettype none
package prm_pkg;
    localparam int         NUM_CHAN      = 8;
    localparam logic [1:0] ADDR_OD_EN    = 2'h0;
    localparam logic [1:0] ADDR_LOCK     = 2'h1;
    localparam logic [1:0] ADDR_STATUS   = 2'h2;
    localparam logic [7:0] OD_EN_RESET   = 8'h00;
    localparam int         LOCK_BIT      = 0;
    localparam int         STAT_LOCK_BIT = 0;
    localparam int         STAT_OWAY_BIT = 1;
endpackage : prm_pkg
`default_nettype wire

// *** src/prm_pin_ctrl.sv ***
// How it works
// R1 - One open-drain enable bit per output: bits 7..3 channels 8..4, 2..0 enhanced 3..1.
// R2 - Bit 1 selects open-drain, 0 normal drive; read/write, reset clears to 0.
// R3 - Remap routing never alters pin direction or drive settings.
// R4 - Routing a peripheral to a pin never enables that peripheral.
// R5 - Analog pin setting wins over remap; analog pin never becomes digital.
// R6 - Software switches analog pins to digital before remapped use.
// R7 - Software maps unused inputs to unused pin, unused pins to null output.
// R8 - Software disables every unneeded remappable peripheral.
// R9 - Software disables idle fixed peripherals sharing a remapped pin.
// R10 - With one-way option set, lock cannot be cleared once set; reset clears it.
// R11 - Open-drain: drive low for 0, driver off for 1.
//
// Our own choices: the strobed register port and the register offsets.
`default_nettype none
module prm_pin_ctrl #(
    parameter int NCH = prm_pkg::NUM_CHAN
) (
    input  wire logic           core_clk_i,
    input  wire logic           reset_i,
    input  wire logic [1:0]     reg_addr_i,
    input  wire logic [7:0]     reg_wdata_i,
    input  wire logic           reg_wr_i,
    input  wire logic           reg_rd_i,
    output logic      [7:0]     reg_rdata_o,
    input  wire logic           lock_one_way_i,
    input  wire logic [NCH-1:0] chan_out_i,
    input  wire logic [NCH-1:0] chan_oe_i,
    input  wire logic [NCH-1:0] pin_analog_i,
    output logic      [NCH-1:0] pin_out_o,
    output logic      [NCH-1:0] pin_oe_o,
    output logic                remap_lock_o
);
    logic [NCH-1:0] od_en_r,   od_en_nxt;
    logic           lock_r,    lock_nxt;
    logic           oway_r,    oway_nxt;
    logic [7:0]     rdata_r,   rdata_nxt;
    logic           wr_od_en;
    logic           wr_lock;
    wire  [NCH-1:0] lane_out;
    wire  [NCH-1:0] lane_oe;

    // Strobe decode; unmapped offsets match nothing, so writes there vanish
    always_comb begin
        wr_od_en = reg_wr_i && (reg_addr_i == prm_pkg::ADDR_OD_EN);
        wr_lock  = reg_wr_i && (reg_addr_i == prm_pkg::ADDR_LOCK);
    end

    // Open-drain enable group
    always_comb begin
        od_en_nxt = od_en_r;
        if (wr_od_en) begin
            od_en_nxt = reg_wdata_i[NCH-1:0]; // see R1 see R2
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (reset_i) begin
            od_en_r <= prm_pkg::OD_EN_RESET[NCH-1:0]; // see R2
        end else begin
            od_en_r <= od_en_nxt;
        end
    end

    // Lock group; option is caught every clock, so a change lags one cycle
    always_comb begin
        oway_nxt = lock_one_way_i;
        lock_nxt = lock_r;
        if (wr_lock) begin
            // Setting always lands; clearing only while not frozen
            if (reg_wdata_i[prm_pkg::LOCK_BIT] || !(lock_r && oway_r)) begin
                lock_nxt = reg_wdata_i[prm_pkg::LOCK_BIT]; // see R10
            end
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (reset_i) begin
            lock_r <= 1'b0; // see R10
            oway_r <= 1'b0;
        end else begin
            lock_r <= lock_nxt;
            oway_r <= oway_nxt;
        end
    end

    // Read group; data stand one cycle only, zero otherwise
    always_comb begin
        rdata_nxt = '0;
        if (reg_rd_i) begin
            case (reg_addr_i)
                prm_pkg::ADDR_OD_EN:  rdata_nxt[NCH-1:0] = od_en_r; // see R1
                prm_pkg::ADDR_LOCK:   rdata_nxt[prm_pkg::LOCK_BIT] = lock_r;
                prm_pkg::ADDR_STATUS: begin
                    rdata_nxt[prm_pkg::STAT_LOCK_BIT] = lock_r;
                    rdata_nxt[prm_pkg::STAT_OWAY_BIT] = oway_r;
                end
                default:              rdata_nxt = '0;
            endcase
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (reset_i) begin
            rdata_r <= '0;
        end else begin
            rdata_r <= rdata_nxt;
        end
    end

    // One lane per channel: analog wins, then open-drain, then plain drive
    for (genvar g = 0; g < NCH; g++) begin : g_lane
        logic out_r, out_nxt;
        logic oe_r,  oe_nxt;

        always_comb begin
            if (pin_analog_i[g]) begin
                out_nxt = 1'b0; // see R5
                oe_nxt  = 1'b0; // see R5
            end else if (od_en_r[g]) begin
                out_nxt = 1'b0; // see R11
                oe_nxt  = chan_oe_i[g] && !chan_out_i[g]; // see R11
            end else begin
                out_nxt = chan_out_i[g]; // see R3 see R4
                oe_nxt  = chan_oe_i[g]; // see R3 see R4
            end
        end

        always_ff @(posedge core_clk_i) begin
            if (reset_i) begin
                out_r <= 1'b0;
                oe_r  <= 1'b0;
            end else begin
                out_r <= out_nxt;
                oe_r  <= oe_nxt;
            end
        end

        assign lane_out[g] = out_r;
        assign lane_oe[g]  = oe_r;

        lane_od_off_a: assert property (@(posedge core_clk_i) disable iff (reset_i) // see R11
            od_en_r[g] && !pin_analog_i[g] && chan_out_i[g] |=> !pin_oe_o[g])
            else $error("open-drain lane drove a one");

        lane_od_low_a: assert property (@(posedge core_clk_i) disable iff (reset_i) // see R11
            od_en_r[g] && !pin_analog_i[g] && !chan_out_i[g]
            |=> !pin_out_o[g] && pin_oe_o[g] == $past(chan_oe_i[g]))
            else $error("open-drain lane low not driven");

        lane_analog_a: assert property (@(posedge core_clk_i) disable iff (reset_i) // see R5
            pin_analog_i[g] |=> !pin_oe_o[g] && !pin_out_o[g])
            else $error("analog lane driven");

        lane_plain_a: assert property (@(posedge core_clk_i) disable iff (reset_i) // see R3
            !od_en_r[g] && !pin_analog_i[g]
            |=> pin_out_o[g] == $past(chan_out_i[g]) && pin_oe_o[g] == $past(chan_oe_i[g]))
            else $error("plain lane drive altered");

        lane_idle_a: assert property (@(posedge core_clk_i) disable iff (reset_i) // see R4
            !chan_oe_i[g] |=> !pin_oe_o[g])
            else $error("lane driven by idle peripheral");
    end : g_lane

    assign reg_rdata_o  = rdata_r;
    assign pin_out_o    = lane_out;
    assign pin_oe_o     = lane_oe;
    assign remap_lock_o = lock_r;

    od_write_a: assert property (@(posedge core_clk_i) disable iff (reset_i) // see R2
        reg_wr_i && reg_addr_i == prm_pkg::ADDR_OD_EN |=> od_en_r == $past(reg_wdata_i[NCH-1:0]))
        else $error("open-drain enable not written");
    lock_hold_a: assert property (@(posedge core_clk_i) disable iff (reset_i) // see R10
        lock_r && oway_r |=> lock_r)
        else $error("lock cleared in one-way mode");
    od_low_a: assert property (@(posedge core_clk_i) disable iff (reset_i) // see R11
        od_en_r[0] && !pin_analog_i[0] && chan_out_i[0] |=> !pin_oe_o[0])
        else $error("open-drain drove high");
    analog_off_a: assert property (@(posedge core_clk_i) disable iff (reset_i) // see R5
        pin_analog_i[0] |=> !pin_oe_o[0])
        else $error("analog pin driven");
    read_back_a: assert property (@(posedge core_clk_i) disable iff (reset_i) // see R1
        reg_rd_i && reg_addr_i == prm_pkg::ADDR_OD_EN |=> reg_rdata_o == $past(od_en_r))
        else $error("read data mismatch");
    push_pull_a: assert property (@(posedge core_clk_i) disable iff (reset_i) // see R3
        !od_en_r[1] && !pin_analog_i[1] |=> pin_oe_o[1] == $past(chan_oe_i[1]))
        else $error("drive changed");
    no_enable_a: assert property (@(posedge core_clk_i) disable iff (reset_i) // see R4
        !chan_oe_i[2] |=> !pin_oe_o[2])
        else $error("pin driven by idle peripheral");
    lock_clr_a: assert property (@(posedge core_clk_i) disable iff (reset_i) // see R10
        !oway_r && reg_wr_i && reg_addr_i == prm_pkg::ADDR_LOCK
        && !reg_wdata_i[prm_pkg::LOCK_BIT] |=> !lock_r)
        else $error("lock not cleared");

    rd_idle_a: assert property (@(posedge core_clk_i) disable iff (reset_i) // see R2
        !reg_rd_i |=> reg_rdata_o == '0)
        else $error("read data outside read cycle");
    od_hold_a: assert property (@(posedge core_clk_i) disable iff (reset_i) // see R2
        !(reg_wr_i && reg_addr_i == prm_pkg::ADDR_OD_EN) |=> od_en_r == $past(od_en_r))
        else $error("open-drain enables changed without write");
    unmapped_rd_a: assert property (@(posedge core_clk_i) disable iff (reset_i) // see R2
        reg_rd_i && reg_addr_i != prm_pkg::ADDR_OD_EN && reg_addr_i != prm_pkg::ADDR_LOCK
        && reg_addr_i != prm_pkg::ADDR_STATUS |=> reg_rdata_o == '0)
        else $error("unmapped offset read nonzero");
    lock_set_a: assert property (@(posedge core_clk_i) disable iff (reset_i) // see R10
        reg_wr_i && reg_addr_i == prm_pkg::ADDR_LOCK && reg_wdata_i[prm_pkg::LOCK_BIT] |=> lock_r)
        else $error("lock not set");
    lock_steady_a: assert property (@(posedge core_clk_i) disable iff (reset_i) // see R10
        !(reg_wr_i && reg_addr_i == prm_pkg::ADDR_LOCK) |=> lock_r == $past(lock_r))
        else $error("lock changed without write");
    status_read_a: assert property (@(posedge core_clk_i) disable iff (reset_i) // see R10
        reg_rd_i && reg_addr_i == prm_pkg::ADDR_STATUS
        |=> reg_rdata_o[prm_pkg::STAT_LOCK_BIT] == $past(lock_r)
        && reg_rdata_o[prm_pkg::STAT_OWAY_BIT] == $past(oway_r))
        else $error("status read mismatch");
    reset_clear_a: assert property (@(posedge core_clk_i) // see R10
        reset_i |=> !remap_lock_o && od_en_r == prm_pkg::OD_EN_RESET[NCH-1:0]
        && pin_oe_o == '0)
        else $error("reset left state behind");

    lock_set_c: cover property (@(posedge core_clk_i) lock_r && oway_r);
    od_use_c:   cover property (@(posedge core_clk_i) od_en_r[0] && pin_oe_o[0]);
    analog_c:   cover property (@(posedge core_clk_i) pin_analog_i[0] && chan_oe_i[0]);
    status_c:   cover property (@(posedge core_clk_i) reg_rd_i && reg_addr_i == prm_pkg::ADDR_STATUS);
    refused_c:  cover property (@(posedge core_clk_i) lock_r && oway_r && wr_lock
        && !reg_wdata_i[prm_pkg::LOCK_BIT]);
endmodule : prm_pin_ctrl
`default_nettype wire

// *** sim/prm_pin_ctrl_bench.sv ***
`default_nettype none
module prm_pin_ctrl_bench;
    timeunit 1ns;
    timeprecision 1ps;
    logic       clk = 1'b0, rst = 1'b1, wr = 1'b0, rd = 1'b0, one_way = 1'b0, lock;
    logic [1:0] addr = 2'h0;
    logic [7:0] wdata = 8'h00, rdata, c_out = 8'h00, c_oe = 8'h00, analog = 8'h00;
    logic [7:0] p_out, p_oe, od = 8'h00;
    int         failures = 0, samples_checked = 0, cycles = 0;
    prm_pin_ctrl #(.NCH(8)) i_dut (.core_clk_i(clk), .reset_i(rst), .reg_addr_i(addr),
        .reg_wdata_i(wdata), .reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdata),
        .lock_one_way_i(one_way), .chan_out_i(c_out), .chan_oe_i(c_oe), .pin_analog_i(analog),
        .pin_out_o(p_out), .pin_oe_o(p_oe), .remap_lock_o(lock));
    initial forever #5 clk = ~clk;
    task automatic check(input string name, input logic [7:0] exp, input logic [7:0] got);
        samples_checked++;
        if (got !== exp) begin
            $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
            failures++;
        end
    endtask
    task automatic wr_reg(input logic [1:0] a, input logic [7:0] d);
        @(posedge clk) begin addr <= a; wdata <= d; wr <= 1'b1; end
        @(posedge clk) wr <= 1'b0;
        if (a == prm_pkg::ADDR_OD_EN) od = d;
    endtask
    task automatic rd_reg(input logic [1:0] a, input logic [7:0] exp);
        @(posedge clk) begin addr <= a; rd <= 1'b1; end
        @(posedge clk) rd <= 1'b0;
        #1 check("rdata", exp, rdata);
    endtask
    // Open-drain lanes never drive a high; analog pins never drive at all
    task automatic pins(input logic [7:0] o, input logic [7:0] e, input logic [7:0] a);
        @(posedge clk) begin c_out <= o; c_oe <= e; analog <= a; end
        repeat (2) @(posedge clk);
        #1 check("pin_oe", e & ~(od & o) & ~a, p_oe);
        check("pin_out_od", 8'h00, p_out & od);
        check("pin_out", o & ~od & ~a, p_out);
    endtask
    task automatic final_report();
        $display("failures %0d samples_checked %0d", failures, samples_checked);
        if (failures == 0 && samples_checked > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    initial forever @(posedge clk) begin
        cycles++;
        if (cycles == 3000) begin failures++; final_report(); end
    end
    initial begin
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        rd_reg(prm_pkg::ADDR_OD_EN, prm_pkg::OD_EN_RESET);
        wr_reg(prm_pkg::ADDR_OD_EN, 8'ha5);
        rd_reg(prm_pkg::ADDR_OD_EN, 8'ha5);
        wr_reg(2'h3, 8'hff);
        rd_reg(2'h3, 8'h00);
        rd_reg(prm_pkg::ADDR_OD_EN, 8'ha5);
        pins(8'h0e, 8'hff, 8'h00);
        pins(8'hf0, 8'hbd, 8'h81);
        wr_reg(prm_pkg::ADDR_OD_EN, 8'h00);
        pins(8'h55, 8'haa, 8'h00);
        pins(8'h00, 8'h00, 8'h00);
        wr_reg(prm_pkg::ADDR_LOCK, 8'h01);
        wr_reg(prm_pkg::ADDR_LOCK, 8'h00);
        #1 check("lock_free", 1'b0, lock);
        @(posedge clk) one_way <= 1'b1;
        wr_reg(prm_pkg::ADDR_LOCK, 8'h01);
        wr_reg(prm_pkg::ADDR_LOCK, 8'h00);
        #1 check("lock_held", 1'b1, lock);
        rd_reg(prm_pkg::ADDR_STATUS, 8'h03);
        wr_reg(prm_pkg::ADDR_OD_EN, 8'h81);
        @(posedge clk) rst <= 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        od = 8'h00;
        #1 check("lock_reset", 1'b0, lock);
        rd_reg(prm_pkg::ADDR_OD_EN, prm_pkg::OD_EN_RESET);
        final_report();
    end
endmodule // prm_pin_ctrl_bench
`default_nettype wire
